// *** psx_ms_timer.sv ***
// Saturating millisecond interval timer used for every supervision delay
`timescale 1ns/1ps
`default_nettype none

module psx_ms_timer #(
  parameter int unsigned W = 13
) (
  input  wire logic         sys_clk_i, // System clock
  input  wire logic         rst_b_i,   // Asynchronous reset, active low
  input  wire logic         clear_i,   // Restart from zero, wins over tick
  input  wire logic         tick_i,    // One-cycle millisecond enable
  output logic [W-1:0]      count_o    // Elapsed milliseconds, saturating
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // Saturation keeps a long wait from wrapping back below a threshold
  always_comb begin
    next_count = count;
    if (clear_i) begin
      next_count = '0;
    end else if (tick_i && (count != {W{1'b1}})) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign count_o = count;

endmodule

`default_nettype wire

// *** psx_supervisor.sv ***
// Power-up sequencing and field current supervision: constants package and top module
//
// Overview of operation
// - Power-up runs initialisation with memory test first
// - Initial faults latched only during initialisation
// - Controlled field reference applied from initialisation start
// - Sample field every 50 ms, ready within 2 s
// - Field fault only with run after configuration
// - No flux: lock at 4 s, report at 6 s
// - Early field loss locks now, reports at 2 s
// - After 100 ms init and ready, show configuration start messages
// - Armature current and speed shown from switch-on
// - High-current ratings light field-on indicator at switch-on
// - Stop fault holds lock until removed and acknowledged
`timescale 1ns/1ps
`default_nettype none

package psx_pkg;
  localparam int unsigned CLK_FREQ_MHZ     = 40;
  localparam int unsigned TIMEBASE_US      = 1000;
  localparam int unsigned MS_CYCLES_DEF    = TIMEBASE_US * CLK_FREQ_MHZ;
  localparam int unsigned DIV_W            = 16;
  localparam int unsigned TMR_W            = 13;
  localparam int unsigned INIT_MS          = 100;
  localparam int unsigned SAMPLE_MS        = 50;
  localparam int unsigned ESTAB_MAX_MS     = 2000;
  localparam int unsigned NOFLUX_LOCK_MS   = 4000;
  localparam int unsigned NOFLUX_REPORT_MS = 6000;
  localparam int unsigned EARLY_LOSS_MS    = 2000;
  localparam int unsigned NUM_INIT_FAULTS  = 5;
  localparam int unsigned IF_RAM           = 0;
  localparam int unsigned IF_REALTIME      = 1;
  localparam int unsigned IF_PROGRAM       = 2;
  localparam int unsigned IF_OPTION_MEM    = 3;
  localparam int unsigned IF_OPTION_SUP    = 4;
  localparam logic [4:0]  INIT_FAULT_RST   = 5'h00;

  typedef enum logic [2:0] {
    PSX_INIT   = 3'b000,
    PSX_ESTAB  = 3'b001,
    PSX_CONFIG = 3'b010,
    PSX_OPER   = 3'b011,
    PSX_HALT   = 3'b100
  } psx_state_t;
endpackage

module psx_supervisor #(
  parameter int unsigned MS_CYCLES = psx_pkg::MS_CYCLES_DEF
) (
  input  wire logic                                sys_clk_i,              // 40 MHz system clock
  input  wire logic                                rst_b_i,                // Power-on reset, active low
  input  wire logic                                run_i,                  // Operator run command pin
  input  wire logic                                fwd_i,                  // Operator forward request pin
  input  wire logic                                rev_i,                  // Operator reverse request pin
  input  wire logic                                field_ok_i,             // Field current established, pin
  input  wire logic                                high_rating_i,          // High-current rating strap pin
  input  wire logic                                controlled_field_i,     // Field in controlled-current mode
  input  wire logic                                ram_fault_i,            // Working memory test failed
  input  wire logic                                realtime_module_fault_i, // Real-time module failed
  input  wire logic                                program_memory_fault_i, // Program memory test failed
  input  wire logic                                option_memory_fault_i,  // Option memory test failed
  input  wire logic                                option_supply_fault_i,  // Option supply failed
  input  wire logic                                config_done_i,          // Configuration dialogue finished
  input  wire logic                                fault_ack_i,            // Operator fault acknowledge pulse
  output logic                                     mem_test_start_o,       // Memory test start pulse
  output logic                                     init_busy_o,            // Initialisation in progress
  output logic [psx_pkg::NUM_INIT_FAULTS-1:0]      init_faults_o,          // Latched initial faults
  output logic                                     field_ref_en_o,         // Apply field current reference
  output logic                                     ready_o,                // Ready for operation
  output logic                                     config_msg_o,           // Show configuration start messages
  output logic                                     display_meas_o,         // Show armature current and speed
  output logic                                     field_on_led_o,         // Field-on indicator
  output logic                                     locked_o,               // Controller locked
  output logic                                     field_fault_o,          // Field current fault reported
  output logic                                     motion_at_powerup_o     // Motion requested during start-up
);
  import psx_pkg::*;

  // Input synchronisers; only the second stage is read
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {high_rating_i, field_ok_i, rev_i, fwd_i, run_i};
      sync2 <= sync1;
    end
  end
  wire logic run_s      = sync2[0];
  wire logic motion_s   = sync2[1] | sync2[2];
  wire logic field_ok_s = sync2[3];
  wire logic rating_s   = sync2[4];

  // Millisecond timebase
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             ms_tick;
  logic             next_ms_tick;
  always_comb begin
    next_div_cnt = div_cnt + 1'b1;
    next_ms_tick = 1'b0;
    if (div_cnt == DIV_W'(MS_CYCLES - 1)) begin
      next_div_cnt = '0;
      next_ms_tick = 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt <= '0;
      ms_tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      ms_tick <= next_ms_tick;
    end
  end

  psx_state_t                 state;
  psx_state_t                 next_state;
  logic [NUM_INIT_FAULTS-1:0] init_faults;
  logic [NUM_INIT_FAULTS-1:0] next_init_faults;
  logic                       started;
  logic                       next_started;
  logic                       led;
  logic                       next_led;
  logic                       motion_seen;
  logic                       next_motion_seen;
  logic                       ready;
  logic                       next_ready;
  logic [TMR_W-1:0]           init_t;
  logic [TMR_W-1:0]           est_t;
  logic [TMR_W-1:0]           smp_t;
  logic [TMR_W-1:0]           run_t;
  logic                       sample_now;

  // Timers share the timebase; each is held at zero outside its phase
  psx_ms_timer #(.W(TMR_W)) u_init_tmr (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .clear_i   (state != PSX_INIT),
    .tick_i    (ms_tick),
    .count_o   (init_t)
  );
  psx_ms_timer #(.W(TMR_W)) u_est_tmr (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .clear_i   (state != PSX_ESTAB),
    .tick_i    (ms_tick),
    .count_o   (est_t)
  );
  psx_ms_timer #(.W(TMR_W)) u_smp_tmr (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .clear_i   ((state != PSX_ESTAB) || sample_now),
    .tick_i    (ms_tick),
    .count_o   (smp_t)
  );
  psx_ms_timer #(.W(TMR_W)) u_run_tmr (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .clear_i   ((state != PSX_OPER) || !run_s),
    .tick_i    (ms_tick),
    .count_o   (run_t)
  );

  assign sample_now = (state == PSX_ESTAB) && (smp_t == TMR_W'(SAMPLE_MS));

  // Start-up sequence
  always_comb begin
    next_state       = state;
    next_init_faults = init_faults;
    next_started     = 1'b1;
    next_led         = led;
    next_motion_seen = motion_seen;
    next_ready       = ready;
    if (state == PSX_INIT) begin // Strap tracked throughout initialisation, frozen after start-up
      next_led = rating_s;
    end
    if ((state == PSX_INIT) || (state == PSX_ESTAB)) begin
      next_motion_seen = motion_seen | motion_s;
    end
    unique case (state)
      PSX_INIT: begin
        // Faults are gathered here only and never cleared while powered
        next_init_faults = init_faults | {option_supply_fault_i, option_memory_fault_i,
                                          program_memory_fault_i, realtime_module_fault_i, ram_fault_i};
        if (init_t >= TMR_W'(INIT_MS)) begin
          next_state = (next_init_faults != '0) ? PSX_HALT : PSX_ESTAB;
        end
      end
      PSX_ESTAB: begin
        if ((sample_now && field_ok_s) || (est_t >= TMR_W'(ESTAB_MAX_MS))) begin
          next_ready = 1'b1;
          next_state = PSX_CONFIG;
        end
      end
      PSX_CONFIG: begin
        if (config_done_i) begin
          next_state = PSX_OPER;
        end
      end
      PSX_OPER: begin
        next_state = PSX_OPER;
      end
      PSX_HALT: begin
        next_state = PSX_HALT;
      end
      default: begin
        next_state = PSX_HALT;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state       <= PSX_INIT;
      init_faults <= INIT_FAULT_RST;
      started     <= 1'b0;
      led         <= 1'b0;
      motion_seen <= 1'b0;
      ready       <= 1'b0;
    end else begin
      state       <= next_state;
      init_faults <= next_init_faults;
      started     <= next_started;
      led         <= next_led;
      motion_seen <= next_motion_seen;
      ready       <= next_ready;
    end
  end

  // Field current supervision, active only when running after configuration
  logic flux_seen;
  logic next_flux_seen;
  logic early_loss;
  logic next_early_loss;
  logic field_fault;
  logic next_field_fault;
  logic supervise;
  logic noflux_lock;
  logic report;

  assign supervise   = (state == PSX_OPER) && run_s;
  assign noflux_lock = supervise && !flux_seen && !field_ok_s && (run_t >= TMR_W'(NOFLUX_LOCK_MS));
  assign report      = supervise && !field_ok_s &&
                       (flux_seen ? (run_t >= TMR_W'(EARLY_LOSS_MS))
                                  : (run_t >= TMR_W'(NOFLUX_REPORT_MS)));

  always_comb begin
    next_flux_seen   = flux_seen;
    next_early_loss  = early_loss;
    next_field_fault = field_fault;
    if (!supervise) begin
      next_flux_seen  = 1'b0;
      next_early_loss = 1'b0;
    end else begin
      if (field_ok_s) begin
        next_flux_seen = 1'b1;
      end
      if (flux_seen && !field_ok_s && (run_t < TMR_W'(EARLY_LOSS_MS))) begin
        next_early_loss = 1'b1;
      end
    end
    // A new report wins over an acknowledge in the same cycle
    if (fault_ack_i && field_ok_s) begin
      next_early_loss  = 1'b0;
      next_field_fault = 1'b0;
    end
    if (report) begin
      next_field_fault = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flux_seen   <= 1'b0;
      early_loss  <= 1'b0;
      field_fault <= 1'b0;
    end else begin
      flux_seen   <= next_flux_seen;
      early_loss  <= next_early_loss;
      field_fault <= next_field_fault;
    end
  end

  assign mem_test_start_o    = (state == PSX_INIT) && !started;
  assign init_busy_o         = (state == PSX_INIT);
  assign init_faults_o       = init_faults;
  assign field_ref_en_o      = controlled_field_i;
  assign ready_o             = ready;
  assign config_msg_o        = (state == PSX_CONFIG);
  assign display_meas_o      = 1'b1;
  assign field_on_led_o      = led;
  assign motion_at_powerup_o = motion_seen;
  assign locked_o            = (state != PSX_OPER) || field_fault || noflux_lock || early_loss;
  assign field_fault_o       = field_fault;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  mem_test_first_a: assert property (mem_test_start_o |-> state == PSX_INIT && init_t == '0)
    else $error("Memory test started outside initialisation");
  init_fault_hold_a: assert property (state != PSX_INIT |=> $stable(init_faults_o))
    else $error("Initial faults changed after initialisation");
  field_ref_init_a: assert property (state == PSX_INIT && controlled_field_i |-> field_ref_en_o)
    else $error("Field reference missing during initialisation");
  ready_bound_a: assert property (state == PSX_ESTAB |-> est_t <= TMR_W'(ESTAB_MAX_MS) && !ready_o)
    else $error("Ready not reached within the establishment limit");
  config_locked_a: assert property (state == PSX_CONFIG |-> locked_o && !report)
    else $error("Unlocked or fault tested during configuration");
  noflux_lock_a: assert property (supervise && !flux_seen && !field_ok_s && run_t >= TMR_W'(NOFLUX_LOCK_MS)
                                  |-> locked_o)
    else $error("No lock after missing flux delay");
  fault_report_a: assert property ($rose(field_fault_o) |-> $past(run_t) >= TMR_W'(EARLY_LOSS_MS))
    else $error("Field fault reported before run window elapsed");
  config_msg_a: assert property (config_msg_o |-> init_faults_o == '0 && ready_o)
    else $error("Configuration messages shown with initial fault");
  init_length_a: assert property ($fell(init_busy_o) |-> $past(init_t) >= TMR_W'(INIT_MS))
    else $error("Initialisation ended before its duration");
  early_lock_a: assert property (supervise && flux_seen && !field_ok_s |=> locked_o)
    else $error("No lock after field current loss");
  display_on_a: assert property (display_meas_o)
    else $error("Measurement display off");
  fault_hold_a: assert property (field_fault_o && !(fault_ack_i && field_ok_s) |=> field_fault_o)
    else $error("Field fault released without acknowledge");
  tick_single_a: assert property (ms_tick |=> !ms_tick [*2])
    else $error("Millisecond tick longer than one cycle");

endmodule

`default_nettype wire

// *** psx_plant_model.sv ***
// Behavioural operator panel and field supply seen by the supervisor
`timescale 1ns/1ps
`default_nettype none

module psx_plant_model #(
  parameter int unsigned MS_CYCLES = 4
) (
  input  wire logic        sys_clk_i,   // System clock
  input  wire logic        rst_b_i,     // Power-on reset, active low
  input  wire logic        run_cmd_i,   // Bench run request
  input  wire logic        fwd_cmd_i,   // Bench forward request
  input  wire logic        rev_cmd_i,   // Bench reverse request
  input  wire logic        supply_i,    // Field supply on
  input  wire logic        init_busy_i, // Supervisor initialising
  input  wire logic [15:0] est_ms_i,    // Field build-up ms, all ones never
  output logic             run_o,       // Run pin
  output logic             fwd_o,       // Forward pin
  output logic             rev_o,       // Reverse pin
  output logic             field_ok_o   // Field established pin
);
  logic [31:0] on_cyc;
  logic        booted;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      on_cyc <= 32'h0000_0000;
      booted <= 1'b0;
    end else begin
      on_cyc <= supply_i ? on_cyc + 32'h0000_0001 : 32'h0000_0000;
      booted <= booted | ~init_busy_i;
    end
  end

  // Motion requests are withheld until the first initialisation is over
  assign fwd_o = fwd_cmd_i & booted;
  assign rev_o = rev_cmd_i & booted;
  assign run_o = run_cmd_i;
  // Current lags the supply by the build-up time but drops with it at once
  assign field_ok_o = supply_i && (est_ms_i != 16'hFFFF) && (on_cyc >= 32'(est_ms_i) * MS_CYCLES);
endmodule

`default_nettype wire

// *** psx_supervisor_tb.sv ***
// Self-checking bench for the power-up and field supervisor
`timescale 1ns/1ps
`default_nettype none

module psx_supervisor_tb;
  import psx_pkg::*;
  localparam int unsigned MS = 4;
  logic        sys_clk_i, rst_b_i, run_c, fwd_c, rev_c, sup, cf, hr, cfg, ack;
  logic        run_i, fwd_i, rev_i, field_ok_i, mts, busy, fref, rdy, cmsg, disp, led, lck, ffl, mpu;
  logic [4:0]  flt, iflt;
  logic [15:0] est;
  wire  [3:0]  mon = {ffl, lck, rdy, busy};
  int          error_cnt, n_checks;

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  psx_supervisor #(.MS_CYCLES(MS)) dut (
    .sys_clk_i, .rst_b_i, .run_i, .fwd_i, .rev_i, .field_ok_i, .high_rating_i(hr), .controlled_field_i(cf),
    .ram_fault_i(flt[0]), .realtime_module_fault_i(flt[1]), .program_memory_fault_i(flt[2]),
    .option_memory_fault_i(flt[3]), .option_supply_fault_i(flt[4]), .config_done_i(cfg), .fault_ack_i(ack),
    .mem_test_start_o(mts), .init_busy_o(busy), .init_faults_o(iflt), .field_ref_en_o(fref), .ready_o(rdy),
    .config_msg_o(cmsg), .display_meas_o(disp), .field_on_led_o(led), .locked_o(lck), .field_fault_o(ffl),
    .motion_at_powerup_o(mpu));

  psx_plant_model #(.MS_CYCLES(MS)) plant (
    .sys_clk_i, .rst_b_i, .run_cmd_i(run_c), .fwd_cmd_i(fwd_c), .supply_i(sup), .init_busy_i(busy),
    .rev_cmd_i(rev_c), .est_ms_i(est), .run_o(run_i), .fwd_o(fwd_i), .rev_o(rev_i), .field_ok_o(field_ok_i));

  task automatic step(int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask

  task automatic chk(logic [4:0] got, logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bounded wait for one monitored output to reach a level
  task automatic wait_on(int sel, logic lvl, int max, output int n);
    n = 0;
    while (mon[sel] !== lvl) begin
      step(1);
      n++;
      if (n > max) begin
        error_cnt++;
        $display("[ERR] %0t wait %h got %h exp %h", $time, sel, mon[sel], lvl);
        test_done();
      end
    end
  endtask

  task automatic pulse_ack();
    ack = 1'b1;
    step(1);
    ack = 1'b0;
    step(2);
  endtask

  task automatic do_reset(logic [4:0] f);
    rst_b_i = 1'b0;
    flt = f;
    {run_c, rev_c, sup, cfg, ack} = 5'h00;
    step(16);
    chk(rdy, 1'b0);
    chk(disp, 1'b1);
    rst_b_i = 1'b1;
    #1;
    chk(mts, 1'b1);
    chk(busy, 1'b1);
    step(1);
    chk(mts, 1'b0);
    step(4);
    chk(led, hr);
    chk(fref, cf);
    chk(lck, 1'b1);
  endtask

  // Each initial fault alone, then a clean start with late field current
  task automatic init_faults();
    int n;
    logic [4:0] f;
    for (int i = 0; i <= 5; i++) begin
      f = (i < 5) ? 5'(1 << i) : 5'h00;
      hr = i[0];
      cf = ~i[0];
      fwd_c = 1'b1;
      do_reset(f);
      step(10);
      flt = 5'h00;
      wait_on(0, 1'b0, 110 * MS, n);
      chk((n + 15 >= 100 * MS - 8) && (n + 15 <= 100 * MS + 8), 1'b1);
      chk(iflt, f);
      chk(mpu, 1'b0);
      fwd_c = 1'b0;
      flt = 5'h1F;
      sup = 1'b1;
      est = 16'h012C;
      step(2);
      chk(iflt, f);
      flt = 5'h00;
      if (i == 5) begin
        wait_on(1, 1'b1, 400 * MS, n);
        chk((n + 2 >= 300 * MS) && (n + 2 <= 350 * MS + 8), 1'b1);
        chk(cmsg, 1'b1);
      end else begin
        step(400 * MS);
        chk(cmsg, 1'b0);
      end
    end
  endtask

  // No field at all: ready at the cap, no supervision during configuration
  task automatic cap_and_config();
    int n;
    do_reset(5'h00);
    wait_on(0, 1'b0, 110 * MS, n);
    rev_c = 1'b1;
    wait_on(1, 1'b1, 2100 * MS, n);
    chk((n >= 2000 * MS - 4) && (n <= 2000 * MS + 8), 1'b1);
    chk(mpu, 1'b1);
    rev_c = 1'b0;
    run_c = 1'b1;
    step(100 * MS);
    chk(ffl, 1'b0);
    chk(lck, 1'b1);
    run_c = 1'b0;
    cfg = 1'b1;
    step(1);
    cfg = 1'b0;
    step(2);
    chk(cmsg, 1'b0);
  endtask

  task automatic early_loss();
    int n;
    sup = 1'b1;
    est = 16'h0000;
    step(5);
    run_c = 1'b1;
    step(5);
    chk(lck, 1'b0);
    step(500 * MS);
    sup = 1'b0;
    step(5);
    chk(lck, 1'b1);
    chk(ffl, 1'b0);
    wait_on(3, 1'b1, 2000 * MS, n);
    chk((n + 5 >= 1495 * MS) && (n + 5 <= 1500 * MS + 8), 1'b1);
    pulse_ack();
    chk(ffl, 1'b1);
    sup = 1'b1;
    step(5);
    pulse_ack();
    chk(ffl, 1'b0);
    chk(lck, 1'b0);
  endtask

  // Supply and run together, flux never builds
  task automatic no_flux();
    int n;
    {run_c, sup} = 2'b00;
    est = 16'hFFFF;
    step(10);
    {run_c, sup} = 2'b11;
    step(3990 * MS);
    chk(lck, 1'b0);
    step(11 * MS);
    chk(lck, 1'b1);
    chk(ffl, 1'b0);
    wait_on(3, 1'b1, 2100 * MS, n);
    chk((n + 4001 * MS >= 6000 * MS) && (n + 4001 * MS <= 6000 * MS + 8), 1'b1);
  endtask

  initial begin
    {rst_b_i, run_c, fwd_c, rev_c, sup, cf, hr, cfg, ack} = 9'h000;
    flt = 5'h00;
    est = 16'hFFFF;
    error_cnt = 0;
    n_checks = 0;
    init_faults();
    cap_and_config();
    early_loss();
    no_flux();
    test_done();
  end
endmodule

`default_nettype wire
